// File: rtl/cbr_pkg.sv
// constants, field layout and types of the charger bus register bank
// assumes a 40 MHz system clock; used by the register bank and the bench by scoped name
package cbr_pkg;

    // command codes of the registers
    localparam logic [7:0] CMD_CHARGE_RATE = 8'h14;
    localparam logic [7:0] CMD_TOP_VOLT    = 8'h15;
    localparam logic [7:0] CMD_CTRL        = 8'h3D;
    localparam logic [7:0] CMD_INPUT_LIMIT = 8'h3F;

    // power-on values
    localparam logic [15:0] CHARGE_RATE_RST = 16'h0000;
    localparam logic [15:0] TOP_VOLT_RST    = 16'h0000;
    localparam logic [15:0] INPUT_LIMIT_RST = 16'h0000;
    localparam logic [5:0]  CTRL_RST        = 6'h00;

    // dac field of the current words
    localparam int          DAC_LSB    = 7;
    localparam int          DAC_MSB    = 12;
    localparam int          UNUSED_LSB = 13;
    localparam logic [5:0]  DAC_FULL   = 6'h3F;

    // control bits
    localparam int CTRL_100K_BIT    = 0;
    localparam int CTRL_50K_BIT     = 1;
    localparam int CTRL_ISO_BIT     = 2;
    localparam int CTRL_LOWP_BIT    = 4;
    localparam int CTRL_ACOK_BIT    = 6;
    localparam int CTRL_TRICKLE_BIT = 7;
    localparam int CTRL_RW_BITS     = 6;

    // bus framing
    localparam logic [3:0] BYTE_BITS  = 4'h8;
    localparam logic [6:0] SLAVE_ADDR = 7'h09;

    // charge watchdog
    localparam longint unsigned WDOG_TIME_S = 175;
    localparam longint unsigned CLK_FREQ_HZ = 40000000;
    localparam logic [35:0]     WDOG_CYCLES = 36'(WDOG_TIME_S * CLK_FREQ_HZ);

    typedef enum logic [1:0] {
        FREQ_NORMAL = 2'b00,
        FREQ_100K   = 2'b01,
        FREQ_50K    = 2'b11
    } cbr_freq_e;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_ADDR = 4'b0001,
        ST_CMD  = 4'b0010,
        ST_WLO  = 4'b0011,
        ST_WHI  = 4'b0100,
        ST_ACK  = 4'b0101,
        ST_RD   = 4'b0110,
        ST_MACK = 4'b0111,
        ST_RDGO = 4'b1000,
        ST_DONE = 4'b1001
    } cbr_state_e;

endpackage

// File: rtl/cbr_smb_sync.sv
// pin synchronisers plus clock edge and start/stop detection
// assumes pins are asynchronous to clk and the bus clock is far slower
`timescale 1ns/10ps
module cbr_smb_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // raw pins
    input  wire logic scl_in,
    input  wire logic sda_in,
    input  wire logic adapter_present,
    input  wire logic trickle_active,
    // synchronised levels
    output logic      scl_s,
    output logic      sda_s,
    output logic      adapter_s,
    output logic      trickle_s,
    // events
    output logic      scl_rise,
    output logic      scl_fall,
    output logic      start_det,
    output logic      stop_det
);
    logic [3:0] raw;
    logic [3:0] meta_reg;
    logic [3:0] sync_reg;
    logic       scl_prev_reg;
    logic       sda_prev_reg;

    assign raw = {trickle_active, adapter_present, sda_in, scl_in};

    // two flops per pin
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_sync
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    meta_reg[i] <= (i < 2) ? 1'b1 : 1'b0;
                    sync_reg[i] <= (i < 2) ? 1'b1 : 1'b0;
                end else begin
                    meta_reg[i] <= raw[i];
                    sync_reg[i] <= meta_reg[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_prev_reg <= sync_reg[0];
            sda_prev_reg <= sync_reg[1];
        end
    end

    assign scl_s     = sync_reg[0];
    assign sda_s     = sync_reg[1];
    assign adapter_s = sync_reg[2];
    assign trickle_s = sync_reg[3];
    assign scl_rise  = sync_reg[0] & ~scl_prev_reg;
    assign scl_fall  = ~sync_reg[0] & scl_prev_reg;
    assign start_det = sync_reg[0] & scl_prev_reg & sda_prev_reg & ~sync_reg[1];
    assign stop_det  = sync_reg[0] & scl_prev_reg & ~sda_prev_reg & sync_reg[1];
endmodule

// File: rtl/cbr_regbank.sv
// bus slave register bank of the regulator/charger with charge watchdog
// assumes bus pins and status pins asynchronous to clk; rst is bus supply power-up
//
// Functional notes
// - input limit word at command 0x3F, word write and read, reads back unchanged.
// - one limit count means 1mA, or 20uV across the sense pins.
// - low seven bits ignored, next six drive the limit dac, 13-15 unused.
// - dac bits weigh 128mA for bit 7 doubling to 4096mA for bit 12.
// - requests above 8.064A clamp to full scale 8.064A.
// - input limit word reloads its power-on value on bus supply power-up.
// - control register at 0x3D; bit 0 alone selects 100kHz switching.
// - control bits 1 and 0 both set select 50kHz switching.
// - control bit 2 floats the adapter switch gate, isolating the adapter.
// - control bit 4 powers down the discharge monitoring circuits.
// - control bits 6 and 7 are internal status; writes to them do nothing.
// - bit 6 shows adapter present, bit 7 shows trickle; both zero by default.
// - all control bits default to zero and return there at power-up.
// - adapter present and no voltage or current write in 175s stops charging.
// - after timeout, charging stays off until voltage or current register written.
// - system voltage regulation continues after timeout; only charging halts.
// - adapter absent turns the battery switch gate on.
// - each transfer is two bytes, low byte first then high byte.
// - voltage and current registers use smart charger command codes and formats.
// - write is address, command, low, high, each acked, then stop commits.
// - read is command write, stop, read address, ack low, nack high, stop.
// - only one register is written or read per transaction.
`timescale 1ns/10ps
module cbr_regbank #(
    parameter logic [6:0]  SLAVE_ADDR  = cbr_pkg::SLAVE_ADDR,
    parameter logic [35:0] WDOG_CYCLES = cbr_pkg::WDOG_CYCLES
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // bus pins
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_n,
    // status pins
    input  wire logic        adapter_present,
    input  wire logic        trickle_active,
    // converter controls
    output logic [5:0]       input_limit_dac_field,
    output logic [5:0]       charge_rate_dac_field,
    output logic [15:0]      top_system_voltage_set,
    output logic [1:0]       freq_mode,
    output logic             adapter_gate_hiz,
    output logic             monitor_power_off,
    output logic             battery_switch_gate_on,
    output logic             charge_enable,
    output logic             regulate_enable
);
    logic        sda_s;
    logic        adapter_s;
    logic        trickle_s;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;

    cbr_pkg::cbr_state_e state_reg;
    cbr_pkg::cbr_state_e ack_next_reg;
    logic [3:0]  bit_cnt_reg;
    logic [7:0]  shift_reg;
    logic [7:0]  cmd_reg;
    logic        cmd_ok_reg;
    logic        is_hi_reg;
    logic [7:0]  lo_reg;
    logic [7:0]  hi_reg;
    logic        wr_full_reg;
    logic        wr_commit_reg;
    logic        sda_oe_n_reg;

    logic [15:0] input_limit_reg;
    logic [15:0] charge_rate_reg;
    logic [15:0] top_system_voltage_reg;
    logic [5:0]  ctrl_reg;
    logic [15:0] rd_word;
    logic        rearm;

    logic [35:0] wdog_cnt_reg;
    logic        expired_reg;
    logic        expire_evt;
    logic [5:0]  limit_dac_next;
    logic [5:0]  rate_dac_next;

    cbr_smb_sync u_sync (
        .clk             (clk),
        .rst             (rst),
        .scl_in          (scl_in),
        .sda_in          (sda_in),
        .adapter_present (adapter_present),
        .trickle_active  (trickle_active),
        .scl_s           (),
        .sda_s           (sda_s),
        .adapter_s       (adapter_s),
        .trickle_s       (trickle_s),
        .scl_rise        (scl_rise),
        .scl_fall        (scl_fall),
        .start_det       (start_det),
        .stop_det        (stop_det)
    );

    // command decode and read data
    always_comb begin
        rd_word   = 16'h0000;
        case (cmd_reg)
            cbr_pkg::CMD_INPUT_LIMIT: rd_word = input_limit_reg;
            cbr_pkg::CMD_CHARGE_RATE: rd_word = charge_rate_reg;
            cbr_pkg::CMD_TOP_VOLT:    rd_word = top_system_voltage_reg;
            cbr_pkg::CMD_CTRL:        rd_word = {8'h00, trickle_s, adapter_s, ctrl_reg};
            default:                  rd_word = 16'h0000;
        endcase
    end

    function automatic logic known_cmd(input logic [7:0] c);
        known_cmd = (c == cbr_pkg::CMD_INPUT_LIMIT) || (c == cbr_pkg::CMD_CHARGE_RATE) ||
                    (c == cbr_pkg::CMD_TOP_VOLT) || (c == cbr_pkg::CMD_CTRL);
    endfunction

    // byte-level slave sequencer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg    <= cbr_pkg::ST_IDLE;
            ack_next_reg <= cbr_pkg::ST_IDLE;
            bit_cnt_reg  <= 4'h0;
            shift_reg    <= 8'h00;
            cmd_reg      <= 8'h00;
            cmd_ok_reg   <= 1'b0;
            is_hi_reg    <= 1'b0;
            lo_reg       <= 8'h00;
            hi_reg       <= 8'h00;
            wr_full_reg  <= 1'b0;
            sda_oe_n_reg <= 1'b1;
        end else if (start_det) begin
            state_reg    <= cbr_pkg::ST_ADDR;
            bit_cnt_reg  <= 4'h0;
            wr_full_reg  <= 1'b0;
            sda_oe_n_reg <= 1'b1;
        end else if (stop_det) begin
            state_reg    <= cbr_pkg::ST_IDLE;
            wr_full_reg  <= 1'b0;
            sda_oe_n_reg <= 1'b1;
        end else begin
            case (state_reg)
                cbr_pkg::ST_ADDR, cbr_pkg::ST_CMD, cbr_pkg::ST_WLO, cbr_pkg::ST_WHI: begin
                    if (scl_rise) begin
                        shift_reg   <= {shift_reg[6:0], sda_s};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (scl_fall && bit_cnt_reg == cbr_pkg::BYTE_BITS) begin
                        bit_cnt_reg <= 4'h0;
                        state_reg   <= cbr_pkg::ST_ACK;
                        case (state_reg)
                            cbr_pkg::ST_ADDR: begin
                                is_hi_reg <= 1'b0;
                                if (shift_reg[7:1] == SLAVE_ADDR &&
                                    (!shift_reg[0] || cmd_ok_reg)) begin
                                    sda_oe_n_reg <= 1'b0;
                                    ack_next_reg <= shift_reg[0] ? cbr_pkg::ST_RD
                                                                 : cbr_pkg::ST_CMD;
                                end else begin
                                    state_reg <= cbr_pkg::ST_IDLE;
                                end
                            end
                            cbr_pkg::ST_CMD: begin
                                cmd_reg    <= shift_reg;
                                cmd_ok_reg <= known_cmd(shift_reg);
                                if (known_cmd(shift_reg)) begin
                                    sda_oe_n_reg <= 1'b0;
                                    ack_next_reg <= cbr_pkg::ST_WLO;
                                end else begin
                                    state_reg <= cbr_pkg::ST_DONE;
                                end
                            end
                            cbr_pkg::ST_WLO: begin
                                lo_reg       <= shift_reg;
                                sda_oe_n_reg <= 1'b0;
                                ack_next_reg <= cbr_pkg::ST_WHI;
                            end
                            default: begin
                                hi_reg       <= shift_reg;
                                wr_full_reg  <= 1'b1;
                                sda_oe_n_reg <= 1'b0;
                                ack_next_reg <= cbr_pkg::ST_DONE;
                            end
                        endcase
                    end
                end
                cbr_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        state_reg <= ack_next_reg;
                        if (ack_next_reg == cbr_pkg::ST_RD) begin
                            sda_oe_n_reg <= rd_word[7];
                            shift_reg    <= {rd_word[6:0], 1'b0};
                            bit_cnt_reg  <= 4'h1;
                        end else begin
                            sda_oe_n_reg <= 1'b1;
                        end
                    end
                end
                cbr_pkg::ST_RD: begin
                    if (scl_fall) begin
                        if (bit_cnt_reg == cbr_pkg::BYTE_BITS) begin
                            sda_oe_n_reg <= 1'b1;
                            bit_cnt_reg  <= 4'h0;
                            state_reg    <= cbr_pkg::ST_MACK;
                        end else begin
                            sda_oe_n_reg <= shift_reg[7];
                            shift_reg    <= {shift_reg[6:0], 1'b0};
                            bit_cnt_reg  <= bit_cnt_reg + 4'h1;
                        end
                    end
                end
                cbr_pkg::ST_MACK: begin
                    if (scl_rise) begin
                        if (!sda_s && !is_hi_reg) begin
                            is_hi_reg <= 1'b1;
                            state_reg <= cbr_pkg::ST_RDGO;
                        end else begin
                            state_reg <= cbr_pkg::ST_DONE;
                        end
                    end
                end
                cbr_pkg::ST_RDGO: begin
                    if (scl_fall) begin
                        sda_oe_n_reg <= rd_word[15];
                        shift_reg    <= {rd_word[14:8], 1'b0};
                        bit_cnt_reg  <= 4'h1;
                        state_reg    <= cbr_pkg::ST_RD;
                    end
                end
                default: sda_oe_n_reg <= 1'b1;
            endcase
        end
    end

    // a full word is committed only on the stop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_commit_reg <= 1'b0;
        end else begin
            wr_commit_reg <= stop_det & wr_full_reg;
        end
    end

    assign rearm = wr_commit_reg &&
                   (cmd_reg == cbr_pkg::CMD_TOP_VOLT || cmd_reg == cbr_pkg::CMD_CHARGE_RATE);

    // register storage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            input_limit_reg        <= cbr_pkg::INPUT_LIMIT_RST;
            charge_rate_reg        <= cbr_pkg::CHARGE_RATE_RST;
            top_system_voltage_reg <= cbr_pkg::TOP_VOLT_RST;
            ctrl_reg               <= cbr_pkg::CTRL_RST;
        end else if (wr_commit_reg) begin
            case (cmd_reg)
                cbr_pkg::CMD_INPUT_LIMIT: input_limit_reg <= {hi_reg, lo_reg};
                cbr_pkg::CMD_CHARGE_RATE: charge_rate_reg <= {hi_reg, lo_reg};
                cbr_pkg::CMD_TOP_VOLT:    top_system_voltage_reg <= {hi_reg, lo_reg};
                cbr_pkg::CMD_CTRL:        ctrl_reg <= lo_reg[cbr_pkg::CTRL_RW_BITS-1:0];
                default:                  ctrl_reg <= ctrl_reg;
            endcase
        end
    end

    // charge watchdog, only while the adapter is present; parks one past expiry so it fires once
    assign expire_evt = adapter_s && (wdog_cnt_reg == WDOG_CYCLES - 36'h1);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdog_cnt_reg <= 36'h0;
        end else if (!adapter_s || rearm) begin
            wdog_cnt_reg <= 36'h0;
        end else if (wdog_cnt_reg != WDOG_CYCLES) begin
            wdog_cnt_reg <= wdog_cnt_reg + 36'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            expired_reg <= 1'b0;
        end else if (expire_evt) begin
            expired_reg <= 1'b1;
        end else if (rearm) begin
            expired_reg <= 1'b0;
        end
    end

    // dac fields with clamp above full scale
    assign limit_dac_next = (|input_limit_reg[15:cbr_pkg::UNUSED_LSB]) ? cbr_pkg::DAC_FULL
                          : input_limit_reg[cbr_pkg::DAC_MSB:cbr_pkg::DAC_LSB];
    assign rate_dac_next  = (|charge_rate_reg[15:cbr_pkg::UNUSED_LSB]) ? cbr_pkg::DAC_FULL
                          : charge_rate_reg[cbr_pkg::DAC_MSB:cbr_pkg::DAC_LSB];

    // registered outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            input_limit_dac_field  <= 6'h00;
            charge_rate_dac_field  <= 6'h00;
            top_system_voltage_set <= 16'h0000;
            freq_mode              <= cbr_pkg::FREQ_NORMAL;
            adapter_gate_hiz       <= 1'b0;
            monitor_power_off      <= 1'b0;
            battery_switch_gate_on <= 1'b0;
            charge_enable          <= 1'b0;
            regulate_enable        <= 1'b0;
            sda_out                <= 1'b0;
            sda_oe_n               <= 1'b1;
        end else begin
            input_limit_dac_field  <= limit_dac_next;
            charge_rate_dac_field  <= rate_dac_next;
            top_system_voltage_set <= top_system_voltage_reg;
            if (ctrl_reg[cbr_pkg::CTRL_100K_BIT] && ctrl_reg[cbr_pkg::CTRL_50K_BIT]) begin
                freq_mode <= cbr_pkg::FREQ_50K;
            end else if (ctrl_reg[cbr_pkg::CTRL_100K_BIT]) begin
                freq_mode <= cbr_pkg::FREQ_100K;
            end else begin
                freq_mode <= cbr_pkg::FREQ_NORMAL;
            end
            adapter_gate_hiz       <= ctrl_reg[cbr_pkg::CTRL_ISO_BIT];
            monitor_power_off      <= ctrl_reg[cbr_pkg::CTRL_LOWP_BIT];
            charge_enable          <= adapter_s && !expired_reg && (rate_dac_next != 6'h00);
            battery_switch_gate_on <= !adapter_s ||
                                      (!expired_reg && (rate_dac_next != 6'h00));
            regulate_enable        <= 1'b1;
            sda_out                <= 1'b0;
            sda_oe_n               <= sda_oe_n_reg;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    limit_readback_a: assert property (
        wr_commit_reg && cmd_reg == cbr_pkg::CMD_INPUT_LIMIT
        |=> input_limit_reg == {$past(hi_reg), $past(lo_reg)} ##1
            rd_word == input_limit_reg || cmd_reg != cbr_pkg::CMD_INPUT_LIMIT)
        else $error("input limit word not stored as written");
    limit_field_a: assert property (
        input_limit_reg[15:13] == 3'b000 |=> input_limit_dac_field == $past(input_limit_reg[12:7]))
        else $error("limit dac field not taken from bits 12 to 7");
    limit_clamp_a: assert property (
        input_limit_reg[15:13] != 3'b000 |=> input_limit_dac_field == 6'h3F)
        else $error("limit above full scale not clamped");
    freq_100k_a: assert property (
        ctrl_reg[1:0] == 2'b01 |=> freq_mode == cbr_pkg::FREQ_100K)
        else $error("bit 0 alone did not select 100kHz");
    freq_50k_a: assert property (
        ctrl_reg[1:0] == 2'b11 |=> freq_mode == cbr_pkg::FREQ_50K)
        else $error("bits 1 and 0 did not select 50kHz");
    adapter_isolate_a: assert property (
        $rose(ctrl_reg[2]) |=> adapter_gate_hiz ##1 adapter_gate_hiz || !ctrl_reg[2])
        else $error("adapter gate not floated");
    low_power_a: assert property (
        ctrl_reg[4] |=> monitor_power_off)
        else $error("monitor power not removed");
    status_bits_a: assert property (
        cmd_reg == cbr_pkg::CMD_CTRL |-> rd_word[7:6] == {trickle_s, adapter_s} &&
                                         rd_word[15:8] == 8'h00)
        else $error("control status bits wrong on read");
    charge_stop_a: assert property (
        adapter_s && expired_reg |=> !battery_switch_gate_on && !charge_enable)
        else $error("charging not stopped after timeout");
    rearm_clear_a: assert property (
        rearm && !expire_evt |=> !expired_reg)
        else $error("timeout not cleared by voltage or current write");
    battery_feed_a: assert property (
        !adapter_s |=> battery_switch_gate_on)
        else $error("battery gate off with adapter absent");
    commit_stop_a: assert property (
        wr_commit_reg |-> $past(stop_det) && $past(wr_full_reg))
        else $error("register written without full word and stop");
    single_reg_a: assert property (
        state_reg == cbr_pkg::ST_DONE |=> sda_oe_n_reg || start_det || $past(start_det))
        else $error("slave drove the bus after its one register");
endmodule

// File: tb/cbr_host.sv
// bus host model: open-drain data, 200 ns bus clock
// assumes a pull-up resolves sda outside
`timescale 1ns/10ps
module cbr_host (
    // bus pins
    output logic      scl,
    output logic      sda_rel,
    input  wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    // data moves mid-low, sampled mid-high
    task automatic bit_x(input logic b, output logic r);
        #75 sda_rel = b;
        #75 scl = 1'b1;
        #25 r = sda;
        #25 scl = 1'b0;
    endtask
    task automatic start_c();
        #75 sda_rel = 1'b1;
        #75 scl = 1'b1;
        #100 sda_rel = 1'b0;
        #100 scl = 1'b0;
    endtask
    task automatic stop_c();
        #75 sda_rel = 1'b0;
        #75 scl = 1'b1;
        #100 sda_rel = 1'b1;
        #100;
    endtask
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic n);
        for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
        bit_x(a, n);
    endtask
    // one register per transaction, low byte first
    task automatic wr(input logic [7:0] c, input logic [15:0] w, output logic n);
        logic [7:0] q;
        logic [3:0] k;
        start_c();
        xfer({cbr_pkg::SLAVE_ADDR, 1'b0}, 1'b1, q, k[0]);
        xfer(c, 1'b1, q, k[1]);
        xfer(w[7:0], 1'b1, q, k[2]);
        xfer(w[15:8], 1'b1, q, k[3]);
        stop_c();
        // bus free time, also lets the commit reach the outputs
        #200;
        n = |k;
    endtask
    // select, stop, restart, ack low, nack high
    task automatic rd(input logic [7:0] c, output logic [15:0] w, output logic n);
        logic [7:0] q;
        logic [2:0] k;
        logic z;
        start_c();
        xfer({cbr_pkg::SLAVE_ADDR, 1'b0}, 1'b1, q, k[0]);
        xfer(c, 1'b1, q, k[1]);
        stop_c();
        start_c();
        xfer({cbr_pkg::SLAVE_ADDR, 1'b1}, 1'b1, q, k[2]);
        xfer(8'hFF, 1'b0, w[7:0], z);
        xfer(8'hFF, 1'b1, w[15:8], z);
        stop_c();
        n = |k;
    endtask
endmodule

// File: tb/cbr_regbank_test.sv
// self-checking bench of the charger bus register bank
// assumes the host model owns the bus pins
`timescale 1ns/10ps
module cbr_regbank_test;
    logic        clk, rst, adapter, trickle, nak, sda_out, sda_oe_n, scl, sda_rel;
    logic        hiz, lowp, battery_switch_gate, chg, reg_en;
    logic [5:0]  dac, cdac;
    logic [15:0] vset, rdw;
    logic [1:0]  freq;
    int          n_errors = 0;
    int          compares = 0;
    wire         sda = sda_rel & (sda_oe_n | sda_out);
    cbr_host h (.scl(scl), .sda_rel(sda_rel), .sda(sda));
    cbr_regbank #(.WDOG_CYCLES(36'h7D0)) DUT (.clk(clk), .rst(rst), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .adapter_present(adapter),
        .trickle_active(trickle), .input_limit_dac_field(dac), .charge_rate_dac_field(cdac),
        .top_system_voltage_set(vset), .freq_mode(freq), .adapter_gate_hiz(hiz),
        .monitor_power_off(lowp), .battery_switch_gate_on(battery_switch_gate), .charge_enable(chg),
        .regulate_enable(reg_en));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic t_reset();
        h.rd(8'h3F, rdw, nak);
        chk(rdw, 16'h0000);
        h.rd(8'h3D, rdw, nak);
        chk(rdw, 16'h0040);
        h.rd(8'h20, rdw, nak);
        chk({15'h0, nak}, 16'h0001);
        $display("test reset done");
    endtask
    task automatic t_limit();
        h.wr(8'h3F, 16'h41A0, nak);
        chk({15'h0, nak}, 16'h0000);
        chk({10'h0, dac}, 16'h003F);
        h.rd(8'h3F, rdw, nak);
        chk(rdw, 16'h41A0);
        h.wr(8'h3F, 16'h0DFF, nak);
        chk({10'h0, dac}, 16'h001B);
        h.wr(8'h3F, 16'hE000, nak);
        chk({10'h0, dac}, 16'h003F);
        $display("test limit done");
    endtask
    task automatic t_ctrl();
        h.wr(8'h3D, 16'h00C7, nak);
        chk({12'h0, freq, hiz, lowp}, 16'h000E);
        h.rd(8'h3D, rdw, nak);
        chk(rdw, 16'h0047);
        trickle = 1'b1;
        h.wr(8'h3D, 16'h0011, nak);
        chk({12'h0, freq, hiz, lowp}, 16'h0005);
        h.rd(8'h3D, rdw, nak);
        chk(rdw, 16'h00D1);
        $display("test control done");
    endtask
    task automatic t_wdog();
        h.wr(8'h14, 16'h0080, nak);
        chk({14'h0, chg, battery_switch_gate}, 16'h0003);
        repeat (2100) @(posedge clk);
        #2;
        chk({13'h0, chg, battery_switch_gate, reg_en}, 16'h0001);
        h.wr(8'h15, 16'h3000, nak);
        chk({14'h0, chg, battery_switch_gate}, 16'h0003);
        chk(vset, 16'h3000);
        @(posedge clk);
        #2 adapter = 1'b0;
        repeat (8) @(posedge clk);
        #2;
        chk({14'h0, chg, battery_switch_gate}, 16'h0001);
        $display("test watchdog done");
    endtask
    task automatic t_repower();
        rst = 1'b1;
        repeat (3) @(posedge clk);
        #2 rst = 1'b0;
        repeat (8) @(posedge clk);
        #2;
        h.rd(8'h3F, rdw, nak);
        chk(rdw, 16'h0000);
        h.rd(8'h3D, rdw, nak);
        chk(rdw, 16'h0080);
        $display("test power-up done");
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        adapter = 1'b1;
        trickle = 1'b0;
        repeat (8) @(posedge clk);
        #2 rst = 1'b0;
        repeat (8) @(posedge clk);
        #2;
        t_reset();
        t_limit();
        t_ctrl();
        t_wdog();
        t_repower();
        complete_run();
    end
    initial begin
        #1000000;
        n_errors++;
        complete_run();
    end
endmodule
